// file: src/acen_pkg.sv
// shared constants and carriers for the acquisition channel enable block
package acen_pkg;

    // register offsets as seen through the parameter interface
    localparam logic [31:0] ADDR_CHAN_ENABLE = 32'h0000_2AF8;
    localparam logic [31:0] ADDR_CHAN_COUNT  = 32'h0000_2AF9;
    localparam logic [31:0] ADDR_CARD_CMD    = 32'h0000_0064;

    // command codes
    localparam logic [31:0] CMD_CARD_RESET = 32'h0000_0001;

    // channel bit values
    localparam logic [3:0] CHAN_BIT_ZERO  = 4'h1;
    localparam logic [3:0] CHAN_BIT_ONE   = 4'h2;
    localparam logic [3:0] CHAN_BIT_TWO   = 4'h4;
    localparam logic [3:0] CHAN_BIT_THREE = 4'h8;

    // fitted-channel limits
    localparam logic [3:0] LIMIT_ONE  = CHAN_BIT_ZERO;
    localparam logic [3:0] LIMIT_TWO  = CHAN_BIT_ZERO | CHAN_BIT_ONE;
    localparam logic [3:0] LIMIT_FOUR = 4'hF;

    // channel counts
    localparam logic [2:0] CNT_ONE  = 3'h1;
    localparam logic [2:0] CNT_TWO  = 3'h2;
    localparam logic [2:0] CNT_FOUR = 3'h4;

    // reset values
    localparam logic [3:0] MASK_DEFAULT  = CHAN_BIT_ZERO;
    localparam logic [2:0] COUNT_DEFAULT = CNT_ONE;

    // field widths
    localparam int MASK_W = 4;
    localparam int CNT_W  = 3;

    // register request from software
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } acen_req_t;

    // answer to software
    typedef struct packed {
        logic        ack;
        logic        value_err;
        logic        addr_err;
        logic [31:0] rdata;
    } acen_rsp_t;

endpackage : acen_pkg

// file: src/acen_pattern_check.sv
// pattern legality check and channel count for one enable value
`timescale 1ns/10ps
`default_nettype none
module acen_pattern_check (
    // candidate value
    input  wire logic [31:0] mask_i,
    input  wire logic [2:0]  fitted_i,
    // verdict
    output logic             valid_o,
    output logic [2:0]       count_o
);
    import acen_pkg::*;

    logic [3:0] limit;
    logic       upper_clear;
    logic       inside_fit;
    logic       legal_count;

    // one bit per channel, so the count is the number of set bits
    assign count_o = 3'(mask_i[0]) + 3'(mask_i[1]) + 3'(mask_i[2]) + 3'(mask_i[3]);

    // unknown fitted codes fall back to the smallest card
    assign limit = (fitted_i == CNT_FOUR) ? LIMIT_FOUR :
                   (fitted_i == CNT_TWO)  ? LIMIT_TWO  : LIMIT_ONE;

    assign upper_clear = (mask_i[31:MASK_W] == '0);
    assign inside_fit  = ((mask_i[MASK_W-1:0] & ~limit) == 4'h0);
    // three channels and no channel both leave memory unevenly split
    assign legal_count = (count_o == CNT_ONE) || (count_o == CNT_TWO) ||
                         (count_o == CNT_FOUR);
    assign valid_o     = upper_clear && inside_fit && legal_count;

endmodule : acen_pattern_check
`default_nettype wire

// file: src/acen_top.sv
// channel enable register bank with pattern check and memory share
//
// Function
// - the enable register is read/write and its value is used by the next run, not the current one.
// - each bit of the enable value stands for exactly one channel.
// - values 1, 2, 4 and 8 enable channels 0, 1, 2 and 3 respectively.
// - a one-channel card accepts only the value for channel 0.
// - a two-channel card accepts channel 0, channel 1 or both.
// - a four-channel card accepts one, two or four channels, never three or none.
// - a write outside the permitted set is refused and answered with a value error.
// - a read-only register returns how many channels the programmed bitmap enables.
// - reading the enable register at any time returns the programmed bitmap.
// - channels beyond those fitted on the card cannot be enabled.
// - all acquisition memory is shared among the enabled channels of a run.
// - the card reset command returns every setting to default and disables outputs.
`timescale 1ns/10ps
`default_nettype none
module acen_top #(
    parameter logic [31:0] MEM_TOTAL_WORDS = 32'h0100_0000
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    // card variant strap, from a pin
    input  wire logic [2:0]       fitted_chans_i,
    // parameter interface
    input  wire acen_pkg::acen_req_t req_i,
    output var acen_pkg::acen_rsp_t rsp_o,
    // run control
    input  wire logic             run_start_i,
    output logic [3:0]            run_chan_mask_o,
    output logic [2:0]            run_chan_count_o,
    output logic [31:0]           chan_mem_words_o,
    output logic                  signal_out_en_o
);
    import acen_pkg::*;

    logic [2:0]  fitted_sync1_reg;
    logic [2:0]  fitted_reg;
    logic [3:0]  chan_enable_mask_reg;
    logic [2:0]  active_channel_count_reg;
    logic [3:0]  run_mask_reg;
    logic [2:0]  run_count_reg;
    logic [31:0] mem_words_reg;
    logic        out_en_reg;
    acen_rsp_t   rsp_reg;
    acen_rsp_t   rsp_next;

    logic        wr_mask;
    logic        rd_mask;
    logic        rd_count;
    logic        wr_cmd;
    logic        card_reset;
    logic        known_addr;
    logic        cand_valid;
    logic [2:0]  cand_count;
    logic        mask_take;
    logic [1:0]  share_shift;

    // the strap comes from a pin, so two flops before anyone looks at it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fitted_sync1_reg <= CNT_ONE;
            fitted_reg       <= CNT_ONE;
        end else begin
            fitted_sync1_reg <= fitted_chans_i;
            fitted_reg       <= fitted_sync1_reg;
        end
    end

    // address decode
    assign wr_mask    = req_i.valid && req_i.write && (req_i.addr == ADDR_CHAN_ENABLE);
    assign rd_mask    = req_i.valid && !req_i.write && (req_i.addr == ADDR_CHAN_ENABLE);
    assign rd_count   = req_i.valid && !req_i.write && (req_i.addr == ADDR_CHAN_COUNT);
    assign wr_cmd     = req_i.valid && req_i.write && (req_i.addr == ADDR_CARD_CMD);
    assign card_reset = wr_cmd && (req_i.wdata == CMD_CARD_RESET);
    // the count register is read-only and the command register write-only
    assign known_addr = wr_mask || rd_mask || rd_count || wr_cmd;

    acen_pattern_check u_check (
        .mask_i   (req_i.wdata),
        .fitted_i (fitted_reg),
        .valid_o  (cand_valid),
        .count_o  (cand_count)
    );

    assign mask_take = wr_mask && cand_valid;

    // answer is built here and registered one cycle later
    assign rsp_next.ack       = req_i.valid;
    assign rsp_next.value_err = wr_mask && !cand_valid;
    assign rsp_next.addr_err  = req_i.valid && !known_addr;
    assign rsp_next.rdata     = rd_mask  ? {28'h000_0000, chan_enable_mask_reg} :
                                rd_count ? {29'h0000_0000, active_channel_count_reg} :
                                32'h0000_0000;

    // memory per channel is a power-of-two split, counts are 1, 2 or 4 only
    assign share_shift = (run_count_reg == CNT_FOUR) ? 2'h2 :
                         (run_count_reg == CNT_TWO)  ? 2'h1 : 2'h0;

    // programmed setting; reset command wins over a write in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan_enable_mask_reg     <= MASK_DEFAULT;
            active_channel_count_reg <= COUNT_DEFAULT;
        end else if (card_reset) begin
            chan_enable_mask_reg     <= MASK_DEFAULT;
            active_channel_count_reg <= COUNT_DEFAULT;
        end else if (mask_take) begin
            chan_enable_mask_reg     <= req_i.wdata[MASK_W-1:0];
            active_channel_count_reg <= cand_count;
        end
    end

    // run setting is copied only at run start, so a write never disturbs a run
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_mask_reg  <= MASK_DEFAULT;
            run_count_reg <= COUNT_DEFAULT;
            out_en_reg    <= 1'b0;
        end else if (card_reset) begin
            run_mask_reg  <= MASK_DEFAULT;
            run_count_reg <= COUNT_DEFAULT;
            out_en_reg    <= 1'b0;
        end else if (run_start_i) begin
            run_mask_reg  <= chan_enable_mask_reg;
            run_count_reg <= active_channel_count_reg;
            out_en_reg    <= 1'b1;
        end
    end

    // memory share follows the run count one cycle later
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_words_reg <= MEM_TOTAL_WORDS;
            rsp_reg       <= '0;
        end else begin
            mem_words_reg <= MEM_TOTAL_WORDS >> share_shift;
            rsp_reg       <= rsp_next;
        end
    end

    assign rsp_o            = rsp_reg;
    assign run_chan_mask_o  = run_mask_reg;
    assign run_chan_count_o = run_count_reg;
    assign chan_mem_words_o = mem_words_reg;
    assign signal_out_en_o  = out_en_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_bad_keeps_mask: assert property (
        (wr_mask && !cand_valid && !card_reset) |=>
        $stable(chan_enable_mask_reg) && $stable(active_channel_count_reg))
        else $error("refused write changed the setting");

    a_bad_value_err: assert property (
        (wr_mask && !cand_valid) |=> rsp_o.ack && rsp_o.value_err)
        else $error("refused write not answered with value error");

    a_good_write_takes: assert property (
        mask_take |=> (chan_enable_mask_reg == $past(req_i.wdata[MASK_W-1:0])) && !rsp_o.value_err)
        else $error("legal write not stored");

    a_count_tracks_mask: assert property (
        active_channel_count_reg == 3'(chan_enable_mask_reg[0]) + 3'(chan_enable_mask_reg[1])
            + 3'(chan_enable_mask_reg[2]) + 3'(chan_enable_mask_reg[3]))
        else $error("channel count disagrees with bitmap");

    a_read_back_mask: assert property (
        rd_mask |=> rsp_o.rdata == {28'h000_0000, $past(chan_enable_mask_reg)})
        else $error("read of enable register wrong");

    a_no_unfitted_chan: assert property (
        $stable(fitted_reg) && (fitted_reg == CNT_ONE) && mask_take |=>
        chan_enable_mask_reg == CHAN_BIT_ZERO)
        else $error("one-channel card took another channel");

    a_reset_cmd_default: assert property (
        card_reset |=> (chan_enable_mask_reg == MASK_DEFAULT) && !signal_out_en_o)
        else $error("card reset did not restore defaults");

    a_run_uses_setting: assert property (
        (run_start_i && !card_reset) |=> run_chan_mask_o == $past(chan_enable_mask_reg))
        else $error("run did not copy programmed bitmap");

    a_mem_share_split: assert property (
        $stable(run_count_reg) |-> (32'(chan_mem_words_o) << share_shift) == MEM_TOTAL_WORDS)
        else $error("memory not split among enabled channels");

endmodule : acen_top
`default_nettype wire

// file: dv/test_acquisition_channel_enable.sv
// self-checking bench for the channel enable register bank
`timescale 1ns/10ps
`default_nettype none
module test_acquisition_channel_enable;
    import acen_pkg::*;
    // small memory size keeps the share figures easy to reckon
    localparam logic [31:0] MEM_WORDS = 32'h0000_1000;
    logic        clk_sys_i;
    logic        rst_n_i;
    logic [2:0]  fitted;
    acen_req_t   req;
    acen_rsp_t   rsp;
    acen_rsp_t   seen;
    logic        run_start;
    logic [3:0]  run_mask;
    logic [2:0]  run_count;
    logic [31:0] mem_words;
    logic        out_en;
    logic [3:0]  cur;
    logic [3:0]  lim;
    logic        ok;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    acen_top #(.MEM_TOTAL_WORDS(MEM_WORDS)) DUT (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fitted_chans_i(fitted),
        .req_i(req), .rsp_o(rsp), .run_start_i(run_start), .run_chan_mask_o(run_mask),
        .run_chan_count_o(run_count), .chan_mem_words_o(mem_words), .signal_out_en_o(out_en)
    );

    // free-running clock, 10 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // one request, entered at a falling edge; answer is looked at in its only cycle
    task automatic acc(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        req = '{valid: 1'b1, write: wr, addr: addr, wdata: data};
        @(negedge clk_sys_i);
        seen = rsp;
        check("ack", 32'h0000_0001, {31'h0, rsp.ack});
        req.valid = 1'b0;
        // idle cycle: the ack pulse must be gone again
        @(negedge clk_sys_i);
        check("ack low", 32'h0000_0000, {31'h0, rsp.ack});
    endtask : acc

    initial begin
        rst_n_i = 1'b0;
        fitted = 3'h4;
        req = '0;
        run_start = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        check("run mask", 32'h0000_0001, {28'h0, run_mask});
        check("mem words", MEM_WORDS, mem_words);
        check("out en", 32'h0000_0000, {31'h0, out_en});
        $display("test reset_defaults done");
        // every pattern on each card variant; illegal ones must leave the setting alone
        cur = MASK_DEFAULT;
        for (int f = 0; f < 3; f++) begin
            fitted = 3'(1 << f);
            lim = 4'((1 << fitted) - 1);
            repeat (3) @(negedge clk_sys_i);
            for (int v = 0; v < 16; v++) begin
                ok = (v != 0) && ((4'(v) & ~lim) == 4'h0) && ($countones(v) != 3);
                acc(1'b1, ADDR_CHAN_ENABLE, 32'(v));
                check("value err", {31'h0, !ok}, {31'h0, seen.value_err});
                check("addr err", 32'h0000_0000, {31'h0, seen.addr_err});
                if (ok) begin
                    cur = 4'(v);
                end
                acc(1'b0, ADDR_CHAN_ENABLE, '0);
                check("mask", {28'h0, cur}, seen.rdata);
                acc(1'b0, ADDR_CHAN_COUNT, '0);
                check("count", 32'($countones(cur)), seen.rdata);
            end
        end
        $display("test pattern_sets done");
        // run takes the programmed setting; later writes wait for the next run
        acc(1'b1, ADDR_CHAN_ENABLE, {28'h0, CHAN_BIT_ZERO | CHAN_BIT_ONE});
        run_start = 1'b1;
        @(negedge clk_sys_i);
        run_start = 1'b0;
        check("run mask", 32'h0000_0003, {28'h0, run_mask});
        check("run count", 32'h0000_0002, {29'h0, run_count});
        check("out en", 32'h0000_0001, {31'h0, out_en});
        @(negedge clk_sys_i);
        check("mem words", MEM_WORDS / 2, mem_words);
        acc(1'b1, ADDR_CHAN_ENABLE, 32'h0000_000F);
        check("run mask", 32'h0000_0003, {28'h0, run_mask});
        run_start = 1'b1;
        @(negedge clk_sys_i);
        run_start = 1'b0;
        @(negedge clk_sys_i);
        check("mem words", MEM_WORDS / 4, mem_words);
        $display("test run_start done");
        // other command codes are taken but leave the running setting alone
        acc(1'b1, ADDR_CARD_CMD, 32'h0000_0002);
        check("addr err", 32'h0000_0000, {31'h0, seen.addr_err});
        check("out en", 32'h0000_0001, {31'h0, out_en});
        check("run mask", 32'h0000_000F, {28'h0, run_mask});
        // card reset command brings everything back to defaults
        acc(1'b1, ADDR_CARD_CMD, CMD_CARD_RESET);
        check("run mask", 32'h0000_0001, {28'h0, run_mask});
        check("out en", 32'h0000_0000, {31'h0, out_en});
        check("run count", 32'h0000_0001, {29'h0, run_count});
        check("mem words", MEM_WORDS, mem_words);
        acc(1'b0, ADDR_CHAN_ENABLE, '0);
        check("mask", 32'h0000_0001, seen.rdata);
        acc(1'b0, ADDR_CHAN_COUNT, '0);
        check("count", 32'h0000_0001, seen.rdata);
        $display("test card_reset done");
        // unmapped place and a write to the read-only count
        acc(1'b0, 32'h0000_1234, '0);
        check("addr err", 32'h0000_0001, {31'h0, seen.addr_err});
        check("rdata", 32'h0000_0000, seen.rdata);
        acc(1'b1, ADDR_CHAN_COUNT, 32'h0000_0003);
        check("addr err", 32'h0000_0001, {31'h0, seen.addr_err});
        acc(1'b0, ADDR_CARD_CMD, '0);
        check("addr err", 32'h0000_0001, {31'h0, seen.addr_err});
        // an unknown strap code behaves as a one-channel card
        fitted = 3'h3;
        repeat (3) @(negedge clk_sys_i);
        acc(1'b1, ADDR_CHAN_ENABLE, 32'h0000_0002);
        check("value err", 32'h0000_0001, {31'h0, seen.value_err});
        acc(1'b0, ADDR_CHAN_ENABLE, '0);
        check("mask", 32'h0000_0001, seen.rdata);
        $display("test bad_access done");
        end_sim();
    end
endmodule : test_acquisition_channel_enable
`default_nettype wire
